// File: include/pipe_defs.vh
// Constants for the three-stage array arithmetic pipeline.
// Assumes a 40 ns core clock; included by bare name.
`ifndef PIPE_DEFS_VH
`define PIPE_DEFS_VH
// Timing
`define PA_CLK_NS         40
`define PA_INTERVAL_NS    160
`define PA_PASS_INTERVALS 36
`define PA_STAGES         3
`define PA_STAGE_CYC ((`PA_INTERVAL_NS*`PA_PASS_INTERVALS)/(`PA_STAGES*`PA_CLK_NS))
// Register offsets (byte addresses)
`define PA_REG_CTRL   8'h00
`define PA_REG_NSN    8'h04
`define PA_REG_STAT   8'h08
`define PA_REG_ACC0   8'h20
`define PA_REG_ACC7   8'h3C
// Control register bits and reset values
`define PA_CTRL_LZC    0
`define PA_CTRL_RSTMIN 1
`define PA_CTRL_RST    1'h1
`define PA_LZC_MAX     5'h17
// Multiplier lane control: round, out select, chain, shift
`define PA_ML_RND   0
`define PA_ML_SEL   1
`define PA_ML_CHN   3
`define PA_ML_SHF   4
`define PA_MSEL_HI  2'h0
`define PA_MSEL_LO  2'h1
`define PA_ROUND_K  48'h000000800000
// Stage C unit control fields
`define PA_AC_FN    0
`define PA_AC_PS    4
`define PA_AC_QS    8
`define PA_AC_SS    12
`define PA_AC_YSEL  14
`define PA_AC_OUT   15
`define PA_AC_WR    16
`define PA_AC_IDX   17
`define PA_AC_SRCS  4'hB
// ALU function codes
`define PA_FN_QMP   4'h0
`define PA_FN_PQ    4'h1
`define PA_FN_ADD   4'h2
`define PA_FN_ADD2  4'h3
`define PA_FN_PMQ   4'h4
`define PA_FN_ADC   4'h5
`define PA_FN_SBC   4'h6
`define PA_FN_OR    4'h7
`define PA_FN_AND   4'h8
`define PA_FN_XOR   4'h9
`define PA_FN_CSEL  4'hA
`define PA_FN_CADD  4'hB
`define PA_FN_SPARE 4'hC
`define PA_FN_CINC  4'hD
`define PA_FN_QQ    4'hE
`define PA_FN_PMQ2  4'hF
`endif

// File: design/mul_lane.v
// One multiplier lane: signed product, neighbour add, round, shift.
// Assumes operands already chosen by the inter-stage selector.
`timescale 1ns/1ps
`include "pipe_defs.vh"
module mul_lane (
  // Operands
  input  wire [23:0] i_mplier,
  input  wire [23:0] i_mcand,
  input  wire [23:0] i_bypass,
  input  wire [47:0] i_nbr_prod,
  // Lane control
  input  wire [5:0]  i_ctrl,
  // Results
  output wire [47:0] o_prod,
  output wire [47:0] o_acc,
  output wire [23:0] o_result
);
  wire signed [47:0] prod;
  wire [47:0]        rnd;
  reg  [23:0]        pick;
  wire [1:0]         sel;

  assign prod   = $signed(i_mplier) * $signed(i_mcand);
  assign o_prod = prod;
  assign o_acc  = prod + (i_ctrl[`PA_ML_CHN] ? i_nbr_prod : 48'h0);
  assign rnd    = o_acc + (i_ctrl[`PA_ML_RND] ? `PA_ROUND_K : 48'h0);
  assign sel    = i_ctrl[`PA_ML_SEL +: 2];

  always @* begin
    if (sel == `PA_MSEL_HI) begin
      pick = rnd[47:24];
    end else if (sel == `PA_MSEL_LO) begin
      pick = o_acc[23:0];
    end else begin
      pick = i_bypass;
    end
  end

  assign o_result = $signed(pick) >>> i_ctrl[`PA_ML_SHF +: 2];
endmodule

// File: design/alu_pair.v
// Paired ALUs of one stage C unit sharing operands P and Q.
// Assumes carry and multiplier sign come from the enclosing stage.
`timescale 1ns/1ps
`include "pipe_defs.vh"
module alu_pair (
  // Operands
  input  wire [23:0] i_p,
  input  wire [23:0] i_q,
  // Control
  input  wire [3:0]  i_func,
  input  wire        i_carry,
  input  wire        i_pos,
  // Results
  output wire [23:0] o_x,
  output wire [23:0] o_y,
  output wire        o_cout
);
  reg  [24:0] xs;
  reg  [24:0] ys;
  wire [24:0] p;
  wire [24:0] q;
  wire [24:0] c;

  assign p = {1'b0, i_p};
  assign q = {1'b0, i_q};
  assign c = {24'h000000, i_carry};

  // Complementary function pairs
  always @* begin
    case (i_func)
      `PA_FN_QMP:  begin xs = q;         ys = q - p; end
      `PA_FN_PQ:   begin xs = p;         ys = q; end
      `PA_FN_ADD:  begin xs = p + q;     ys = q - p; end
      `PA_FN_ADD2: begin xs = p + q;     ys = q + p; end
      `PA_FN_PMQ:  begin xs = p - q;     ys = q; end
      `PA_FN_ADC:  begin xs = p + q + c; ys = q - p + c - 25'h1; end
      `PA_FN_SBC:  begin xs = p - q + c - 25'h1; ys = q + p + c; end
      `PA_FN_OR:   begin xs = p | q;     ys = q | p; end
      `PA_FN_AND:  begin xs = p & q;     ys = q & p; end
      `PA_FN_XOR:  begin xs = p ^ q;     ys = ~(q ^ p); end
      `PA_FN_CSEL: begin
        xs = i_pos ? p : q;
        ys = i_pos ? q : p;
      end
      `PA_FN_CADD: begin xs = i_pos ? p + q : p - q; ys = q | p; end
      `PA_FN_CINC: begin
        xs = i_pos ? p + c : p + c - 25'h1;
        ys = i_pos ? q + c - 25'h1 : q + c;
      end
      `PA_FN_QQ:   begin xs = q;         ys = q; end
      `PA_FN_PMQ2: begin xs = p - q;     ys = q; end
      default:     begin xs = 25'h0;     ys = 25'h0; end
    endcase
  end

  assign o_x    = xs[23:0];
  assign o_y    = ys[23:0];
  assign o_cout = xs[24];
endmodule

// File: design/array_pipe.v
// Three-stage arithmetic pipeline: characterizer, multipliers, ALUs.
// Assumes a command decoder feeding per-pass control with each data set
// and memory returning table words during the characterizer stage.
// Notes on behaviour
// - Three stages in sequence, each holding its own data set.
// - Eight 24-bit operands enter, four 24-bit results leave.
// - New set enters as previous one advances; results every stage.
// - Characterizer passes pairs through or alters 3rd/4th addresses.
// - Modifier from top real bits, real/imag bits, or leading zeros.
// - Three-bit code picks the method; code zero means no change.
// - Full 48-bit product, rounded or truncated to 24 bits.
// - Double precision yields high and low words of one product.
// - Control picks multiplier, multiplicand and bypass per lane.
// - Lane forwards upper half, lower half, or bypass operand.
// - Lane accumulator may add the neighbour's product.
// - Result optionally shifted down arithmetically zero to three.
// - Crossbar routes any characterizer output to lane operands.
// - Four units of two ALUs; operands from mults and accumulators.
// - Accumulators loadable by earlier pass or by current pass.
// - Sign of a chosen multiplier output steers conditional functions.
// - Both ALUs share P and Q; one code picks the pair.
// - Unit output goes to pipeline output, an accumulator, or both.
// - Leading-zero count keeps the smaller of new and retained.
// - Function end offers minimum as normalize shift; may be disabled.
// - Decoded control travels alongside its data set.
// - ALU function pairs follow the fixed sixteen-code table.
// - A pass takes 36 intervals of 160 ns.
// - Pipeline halts and holds its stage state while the bus is stolen; register-port writes still land.
`timescale 1ns/1ps
`include "pipe_defs.vh"
module array_pipe (
  // Clock and reset
  input  wire        i_core_clk,
  input  wire        i_rst,
  // Register port
  input  wire [7:0]  i_reg_addr,
  input  wire [31:0] i_reg_wdata,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  output wire [31:0] o_reg_rdata,
  // Memory bus stolen by other masters
  input  wire        i_bus_steal,
  // Source data set
  input  wire        i_set_valid,
  input  wire [23:0] i_first_pair_real,
  input  wire [23:0] i_first_pair_imag,
  input  wire [23:0] i_second_pair_real,
  input  wire [23:0] i_second_pair_imag,
  input  wire [23:0] i_third_source_operand_re,
  input  wire [23:0] i_third_source_operand_im,
  input  wire [23:0] i_fourth_source_operand_re,
  input  wire [23:0] i_fourth_source_operand_im,
  // Table words fetched at modified addresses
  input  wire [23:0] i_tbl3_data,
  input  wire [23:0] i_tbl4_data,
  // Decoded pipeline command for this set
  input  wire        i_char_lookup,
  input  wire [2:0]  i_char_code,
  input  wire [35:0] i_xbar_sel,
  input  wire [23:0] i_mul_ctrl,
  input  wire        i_dbl,
  input  wire [79:0] i_alu_ctrl,
  input  wire        i_lzc_en,
  input  wire        i_func_end,
  // Stage progress and address modifiers
  output wire        o_set_taken,
  output wire [7:0]  o_addr3_mod,
  output wire [7:0]  o_addr4_mod,
  // Results
  output wire        o_res_valid,
  output wire [3:0]  o_res_mask,
  output wire [23:0] o_mult_out_one,
  output wire [23:0] o_mult_out_two,
  output wire [23:0] o_mult_out_three,
  output wire [23:0] o_mult_out_four,
  output wire        o_nsn_valid,
  output wire [4:0]  o_shifts_to_normalize
);
  localparam integer STAGE_END  = `PA_STAGE_CYC - 1;
  localparam [5:0]   STAGE_LAST = STAGE_END[5:0];

  ////////////////////////////////////////////////////////////////////////
  // Functions

  function [4:0] lead_cnt;
    input [23:0] v;
    integer k;
    reg done;
    begin
      lead_cnt = 5'h00;
      done = 1'b0;
      for (k = 22; k >= 0; k = k - 1) begin
        if (!done && v[k] == v[23]) begin
          lead_cnt = lead_cnt + 5'h01;
        end else begin
          done = 1'b1;
        end
      end
    end
  endfunction

  function [7:0] char_mod;
    input [2:0]  code;
    input [23:0] re;
    input [23:0] im;
    begin
      case (code)
        3'h1:    char_mod = {4'h0, re[23:20]};
        3'h2:    char_mod = {2'h0, re[23:18]};
        3'h3:    char_mod = re[23:16];
        3'h4:    char_mod = {4'h0, re[23:22], im[23:22]};
        3'h5:    char_mod = {re[23:20], im[23:20]};
        3'h6:    char_mod = {3'h0, lead_cnt(re)};
        3'h7:    char_mod = {re[23], 2'h0, lead_cnt(re)};
        default: char_mod = 8'h00;
      endcase
    end
  endfunction

  function [4:0] min5;
    input [4:0] a;
    input [4:0] b;
    begin
      min5 = (a < b) ? a : b;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  reg [5:0]   cnt_ff;
  reg         va_ff, vb_ff, vc_ff;
  reg [191:0] a_ops_ff;
  reg         a_look_ff;
  reg [35:0]  a_xbar_ff;
  reg [23:0]  a_mul_ff, b_mul_ff;
  reg         a_dbl_ff, b_dbl_ff;
  reg [79:0]  a_alu_ff, b_alu_ff, c_alu_ff;
  reg [2:0]   a_lzc_ff, b_lzc_ff, c_lzc_ff;
  reg [287:0] b_ops_ff;
  reg [95:0]  c_mout_ff;
  reg [23:0]  acc_ff [0:7];
  reg [3:0]   carry_ff;
  reg [4:0]   min_ff;
  reg         ctrl_lzc_ff;
  reg         taken_ff, res_valid_ff, nsn_valid_ff;
  reg [3:0]   res_mask_ff;
  reg [95:0]  res_ff;
  reg [4:0]   nsn_ff;
  reg [7:0]   mod3_ff, mod4_ff;
  reg [31:0]  rdata_ff;

  wire        tick;
  wire [191:0] ch;
  wire [191:0] prod_flat;
  wire [191:0] acc_flat;
  wire [95:0]  m_out;
  wire [191:0] accr_flat;
  wire [287:0] srcs;
  wire [95:0]  unit_val;
  wire [3:0]   unit_cout;
  wire [3:0]   acc_hit;
  reg  [4:0]   pass_min;
  reg  [4:0]   new_min;
  integer      u;
  integer      j;

  ////////////////////////////////////////////////////////////////////////
  // Stage advance: one stage per third of a pass, frozen during steal

  assign tick = (cnt_ff == STAGE_LAST) && !i_bus_steal;

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_ff <= 6'h00;
    end else if (!i_bus_steal) begin
      cnt_ff <= (cnt_ff == STAGE_LAST) ? 6'h00 : cnt_ff + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stage A output: table words replace third and fourth real operands

  assign ch = {a_ops_ff[191:168],
               a_look_ff ? i_tbl4_data : a_ops_ff[167:144],
               a_ops_ff[143:120],
               a_look_ff ? i_tbl3_data : a_ops_ff[119:96],
               a_ops_ff[95:0]};

  ////////////////////////////////////////////////////////////////////////
  // Stage B lanes and stage C units

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : lane
      wire [23:0] res;
      wire [23:0] p;
      wire [23:0] q;
      wire [19:0] ac;
      wire [23:0] unit_val_x;
      wire [23:0] unit_val_y;

      mul_lane u_mul (
        .i_mplier   (b_ops_ff[g*72 +: 24]),
        .i_mcand    (b_ops_ff[g*72+24 +: 24]),
        .i_bypass   (b_ops_ff[g*72+48 +: 24]),
        .i_nbr_prod (prod_flat[((g+1)%4)*48 +: 48]),
        .i_ctrl     (b_mul_ff[g*6 +: 6]),
        .o_prod     (prod_flat[g*48 +: 48]),
        .o_acc      (acc_flat[g*48 +: 48]),
        .o_result   (res)
      );

      // Even lane gives high word, odd lane the low word of the pair
      if (g % 2 == 0) begin : ev
        assign m_out[g*24 +: 24] = b_dbl_ff ?
                                   acc_flat[g*48+24 +: 24] : res;
      end else begin : od
        assign m_out[g*24 +: 24] = b_dbl_ff ?
                                   acc_flat[(g-1)*48 +: 24] : res;
      end

      assign ac = c_alu_ff[g*20 +: 20];
      assign p  = (ac[`PA_AC_PS +: 4] > `PA_AC_SRCS) ? 24'h000000 :
                  srcs[ac[`PA_AC_PS +: 4]*24 +: 24];
      assign q  = (ac[`PA_AC_QS +: 4] > `PA_AC_SRCS) ? 24'h000000 :
                  srcs[ac[`PA_AC_QS +: 4]*24 +: 24];

      alu_pair u_alu (
        .i_p     (p),
        .i_q     (q),
        .i_func  (ac[`PA_AC_FN +: 4]),
        .i_carry (carry_ff[g]),
        .i_pos   (~c_mout_ff[ac[`PA_AC_SS +: 2]*24+23]),
        .o_x     (unit_val_x),
        .o_y     (unit_val_y),
        .o_cout  (unit_cout[g])
      );

      assign unit_val[g*24 +: 24] = ac[`PA_AC_YSEL] ? unit_val_y : unit_val_x;
      assign accr_flat[g*24 +: 24] = acc_ff[g];
      assign accr_flat[(g+4)*24 +: 24] = acc_ff[g+4];
      assign acc_hit[g] = vc_ff && ac[`PA_AC_WR];
    end
  endgenerate

  assign srcs = {accr_flat, c_mout_ff};

  ////////////////////////////////////////////////////////////////////////
  // Minimum leading-zero count over units sent to the output

  always @* begin
    pass_min = `PA_LZC_MAX;
    for (j = 0; j < 4; j = j + 1) begin
      if (c_alu_ff[j*20+`PA_AC_OUT]) begin
        pass_min = min5(pass_min, lead_cnt(unit_val[j*24 +: 24]));
      end
    end
    new_min = min5(min_ff, pass_min);
  end

  ////////////////////////////////////////////////////////////////////////
  // Pipeline registers

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      va_ff        <= 1'b0;
      vb_ff        <= 1'b0;
      vc_ff        <= 1'b0;
      taken_ff     <= 1'b0;
      res_valid_ff <= 1'b0;
      nsn_valid_ff <= 1'b0;
      res_mask_ff  <= 4'h0;
      carry_ff     <= 4'h0;
      min_ff       <= `PA_LZC_MAX;
      nsn_ff       <= `PA_LZC_MAX;
      for (u = 0; u < 8; u = u + 1) begin
        acc_ff[u] <= 24'h000000;
      end
    end else begin
      taken_ff     <= 1'b0;
      res_valid_ff <= 1'b0;
      nsn_valid_ff <= 1'b0;
      // Software preload of an accumulator before a pass
      if (i_reg_wr && i_reg_addr >= `PA_REG_ACC0 &&
          i_reg_addr <= `PA_REG_ACC7 && i_reg_addr[1:0] == 2'h0) begin
        acc_ff[i_reg_addr[4:2]] <= i_reg_wdata[23:0];
      end
      if (i_reg_wr && i_reg_addr == `PA_REG_CTRL &&
          i_reg_wdata[`PA_CTRL_RSTMIN]) begin
        min_ff <= `PA_LZC_MAX;
      end
      if (tick) begin
        // Empty slots advance too, so the last set drains
        va_ff    <= i_set_valid;
        vb_ff    <= va_ff;
        vc_ff    <= vb_ff;
        taken_ff <= i_set_valid;
        // Stage A capture with its command
        a_ops_ff  <= {i_fourth_source_operand_im, i_fourth_source_operand_re,
                      i_third_source_operand_im, i_third_source_operand_re,
                      i_second_pair_imag, i_second_pair_real,
                      i_first_pair_imag, i_first_pair_real};
        a_look_ff <= i_char_lookup;
        a_xbar_ff <= i_xbar_sel;
        a_mul_ff  <= i_mul_ctrl;
        a_dbl_ff  <= i_dbl;
        a_alu_ff  <= i_alu_ctrl;
        a_lzc_ff  <= {i_func_end, i_lzc_en, i_set_valid};
        mod3_ff   <= i_char_lookup ? char_mod(i_char_code,
                     i_first_pair_real, i_first_pair_imag) : 8'h00;
        mod4_ff   <= i_char_lookup ? char_mod(i_char_code,
                     i_second_pair_real, i_second_pair_imag) : 8'h00;
        // Stage B capture through the crossbar
        for (u = 0; u < 4; u = u + 1) begin
          b_ops_ff[u*72 +: 24]    <= ch[a_xbar_ff[u*9 +: 3]*24 +: 24];
          b_ops_ff[u*72+24 +: 24] <= ch[a_xbar_ff[u*9+3 +: 3]*24 +: 24];
          b_ops_ff[u*72+48 +: 24] <= ch[a_xbar_ff[u*9+6 +: 3]*24 +: 24];
        end
        b_mul_ff  <= a_mul_ff;
        b_dbl_ff  <= a_dbl_ff;
        b_alu_ff  <= a_alu_ff;
        b_lzc_ff  <= a_lzc_ff;
        // Stage C capture
        c_mout_ff <= m_out;
        c_alu_ff  <= b_alu_ff;
        c_lzc_ff  <= b_lzc_ff;
        // Stage C results out and into accumulators
        if (vc_ff) begin
          res_valid_ff <= 1'b1;
          res_ff       <= unit_val;
          carry_ff     <= unit_cout;
          for (u = 0; u < 4; u = u + 1) begin
            res_mask_ff[u] <= c_alu_ff[u*20+`PA_AC_OUT];
            if (acc_hit[u]) begin
              acc_ff[c_alu_ff[u*20+`PA_AC_IDX +: 3]] <=
                unit_val[u*24 +: 24];
            end
          end
          // Normalize tracking, optionally inhibited
          if (c_lzc_ff[1] && ctrl_lzc_ff) begin
            min_ff <= new_min;
          end
          if (c_lzc_ff[2]) begin
            nsn_valid_ff <= 1'b1;
            nsn_ff       <= (c_lzc_ff[1] && ctrl_lzc_ff) ? new_min : min_ff;
            min_ff       <= `PA_LZC_MAX;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port

  always @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_lzc_ff <= `PA_CTRL_RST;
      rdata_ff    <= 32'h00000000;
    end else begin
      if (i_reg_wr && i_reg_addr == `PA_REG_CTRL) begin
        ctrl_lzc_ff <= i_reg_wdata[`PA_CTRL_LZC];
      end
      rdata_ff <= 32'h00000000;
      if (i_reg_rd) begin
        if (i_reg_addr == `PA_REG_CTRL) begin
          rdata_ff <= {31'h0, ctrl_lzc_ff};
        end else if (i_reg_addr == `PA_REG_NSN) begin
          rdata_ff <= {19'h0, min_ff, 3'h0, nsn_ff};
        end else if (i_reg_addr == `PA_REG_STAT) begin
          rdata_ff <= {28'h0, i_bus_steal, vc_ff, vb_ff, va_ff};
        end else if (i_reg_addr >= `PA_REG_ACC0 &&
                     i_reg_addr <= `PA_REG_ACC7 &&
                     i_reg_addr[1:0] == 2'h0) begin
          rdata_ff <= {8'h00, acc_ff[i_reg_addr[4:2]]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_reg_rdata           = rdata_ff;
  assign o_set_taken           = taken_ff;
  assign o_addr3_mod           = mod3_ff;
  assign o_addr4_mod           = mod4_ff;
  assign o_res_valid           = res_valid_ff;
  assign o_res_mask            = res_mask_ff;
  assign o_mult_out_one        = res_ff[23:0];
  assign o_mult_out_two        = res_ff[47:24];
  assign o_mult_out_three      = res_ff[71:48];
  assign o_mult_out_four       = res_ff[95:72];
  assign o_nsn_valid           = nsn_valid_ff;
  assign o_shifts_to_normalize = nsn_ff;
endmodule

// File: testbench/array_pipe_sva.sv
// Port-level checks on the three-stage arithmetic pipeline.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module array_pipe_sva (
  // Clock and reset
  input wire        i_core_clk,
  input wire        i_rst,
  // Inputs watched
  input wire        i_bus_steal,
  input wire        i_set_valid,
  input wire        i_char_lookup,
  input wire [2:0]  i_char_code,
  input wire [23:0] i_first_pair_real,
  input wire [23:0] i_second_pair_real,
  // Outputs watched
  input wire        o_set_taken,
  input wire [7:0]  o_addr3_mod,
  input wire [7:0]  o_addr4_mod,
  input wire        o_res_valid,
  input wire [3:0]  o_res_mask,
  input wire [23:0] o_mult_out_one,
  input wire        o_nsn_valid,
  input wire [4:0]  o_shifts_to_normalize
);
  logic [5:0] gap_ff;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////
  // Cycles since the last capture, saturating
  always @(posedge i_core_clk) begin
    if (i_rst)
      gap_ff <= 6'h3F;
    else if (o_set_taken)
      gap_ff <= 6'h00;
    else if (gap_ff != 6'h3F)
      gap_ff <= gap_ff + 6'h01;
  end
  ////////////////////////////////////////////////////////////////////////
  chk_reset_state: assert property (disable iff (1'b0) i_rst |=>
    !o_res_valid && !o_set_taken && !o_nsn_valid && o_res_mask == 4'h0
    && o_shifts_to_normalize == 5'h17) else $error("reset state wrong");
  chk_tick_spacing: assert property (o_set_taken |-> gap_ff >= 6'h2F)
    else $error("captures too close");
  chk_taken_cause: assert property (o_set_taken |->
    $past(i_set_valid) && !$past(i_bus_steal)) else $error("bad capture");
  chk_steal_freeze: assert property (i_bus_steal |=>
    !o_set_taken && !o_res_valid && $stable(o_mult_out_one))
    else $error("pipeline moved during steal");
  chk_pulse_once: assert property (o_res_valid |=> !o_res_valid)
    else $error("result pulse too long");
  chk_nsn_with_res: assert property (o_nsn_valid |-> o_res_valid
    && o_shifts_to_normalize <= 5'h17) else $error("bad normalize offer");
  chk_plain_addr: assert property (o_set_taken && (!$past(i_char_lookup)
    || $past(i_char_code) == 3'h0) |-> o_addr3_mod == 8'h00
    && o_addr4_mod == 8'h00) else $error("address modified");
  chk_code_three: assert property (o_set_taken && $past(i_char_lookup)
    && $past(i_char_code) == 3'h3 |->
    o_addr3_mod == $past(i_first_pair_real[23:16])
    && o_addr4_mod == $past(i_second_pair_real[23:16]))
    else $error("modifier wrong");
  cov_result: cover property (o_res_valid && o_res_mask == 4'hF);
  cov_nsn: cover property (o_nsn_valid);
  cov_lookup: cover property (o_set_taken && o_addr3_mod == 8'h5A);
endmodule
bind array_pipe array_pipe_sva u_sva (.*);

// File: testbench/mem_partner.sv
// Data memory side: table words and cycle stealing bursts.
// Assumes modifiers are held through the characterizer stage.
`timescale 1ns/1ps
module mem_partner #(
  parameter int STEAL_LEN = 20
) (
  // Clock and reset
  input  wire        i_core_clk,
  input  wire        i_rst,
  // Requests
  input  wire        i_steal_go,
  input  wire [7:0]  i_addr3_mod,
  input  wire [7:0]  i_addr4_mod,
  // Memory side
  output wire        o_bus_steal,
  output wire [23:0] o_tbl3_data,
  output wire [23:0] o_tbl4_data
);
  logic [7:0] steal_cnt_ff;
  // Table word carries its own address
  assign o_tbl3_data = {16'h00A0, i_addr3_mod};
  assign o_tbl4_data = {16'h00B0, i_addr4_mod};
  // Bus taken for a fixed burst
  assign o_bus_steal = steal_cnt_ff != 8'h00;
  always @(posedge i_core_clk) begin
    if (i_rst)
      steal_cnt_ff <= 8'h00;
    else if (i_steal_go)
      steal_cnt_ff <= 8'(STEAL_LEN);
    else if (o_bus_steal)
      steal_cnt_ff <= steal_cnt_ff - 8'h01;
  end
endmodule

// File: testbench/three_stage_array_pipeline_tb_top.sv
// Self-checking bench for the array pipeline and its memory side.
// Assumes the 25 MHz core clock and a 48-cycle stage tick.
`timescale 1ns/1ps
`include "pipe_defs.vh"
module three_stage_array_pipeline_tb_top;
  localparam int STEAL_LEN = 20;
  logic        i_core_clk, i_rst, i_reg_wr, i_reg_rd, i_set_valid, steal_go;
  logic        i_char_lookup, i_dbl, i_lzc_en, i_func_end, i_bus_steal;
  logic        o_set_taken, o_res_valid, o_nsn_valid;
  logic [2:0]  i_char_code;
  logic [3:0]  o_res_mask;
  logic [4:0]  o_shifts_to_normalize;
  logic [7:0]  i_reg_addr, o_addr3_mod, o_addr4_mod;
  logic [31:0] i_reg_wdata, o_reg_rdata;
  logic [23:0] i_first_pair_real, i_first_pair_imag, i_second_pair_real;
  logic [23:0] i_second_pair_imag, i_third_source_operand_re;
  logic [23:0] i_third_source_operand_im, i_fourth_source_operand_re;
  logic [23:0] i_fourth_source_operand_im, i_tbl3_data, i_tbl4_data;
  logic [23:0] o_mult_out_one, o_mult_out_two, o_mult_out_three;
  logic [23:0] o_mult_out_four, i_mul_ctrl;
  logic [35:0] i_xbar_sel;
  logic [79:0] i_alu_ctrl;
  int          bad_count, checked, cyc;
  array_pipe dut (.*);
  mem_partner #(.STEAL_LEN(STEAL_LEN)) partner (
    .i_core_clk (i_core_clk), .i_rst (i_rst), .i_steal_go (steal_go),
    .i_addr3_mod(o_addr3_mod), .i_addr4_mod(o_addr4_mod),
    .o_bus_steal(i_bus_steal), .o_tbl3_data(i_tbl3_data),
    .o_tbl4_data(i_tbl4_data));
  always #20 i_core_clk = ~i_core_clk;
  ////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask
  task reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_core_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    #1 check(o_reg_rdata, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task test_regs;
    logic [31:0] d;
    reg_rd(`PA_REG_ACC0, 32'h0);
    reg_rd(`PA_REG_STAT, 32'h0);
    reg_wr(`PA_REG_ACC0, 32'h00ABCDEF);
    reg_wr(`PA_REG_ACC7, 32'h00123456);
    reg_rd(`PA_REG_ACC0, 32'h00ABCDEF);
    reg_rd(`PA_REG_ACC7, 32'h00123456);
    reg_rd(8'h10, 32'h0);
    reg_rd(`PA_REG_CTRL, 32'h1);
    reg_rd(`PA_REG_NSN, 32'h00001717);
    d = o_reg_rdata;
    check(d & 32'h1F00, 32'h1700);
    $display("test_regs done");
  endtask
  // One pass: lanes round, truncate, bypass, low half shifted
  task run_pass(input logic look, input logic steal);
    int n;
    @(posedge i_core_clk);
    i_set_valid <= 1'b1;
    i_char_lookup <= look;
    i_first_pair_real <= 24'h5A0000;
    i_first_pair_imag <= 24'h001000;
    i_second_pair_real <= 24'h000007;
    i_second_pair_imag <= 24'h000004;
    i_third_source_operand_im <= 24'h000800;
    i_fourth_source_operand_re <= 24'h123456;
    i_xbar_sel <= {9'h01A, look ? 9'h100 : 9'h180, 9'h029, 9'h029};
    i_mul_ctrl <= {6'h22, 6'h04, 6'h00, 6'h01};
    i_alu_ctrl <= {20'h08031, 20'h08021, 20'h08011, 20'h38001};
    n = 0;
    do begin
      @(posedge i_core_clk);
      #1 n++;
    end while (o_set_taken !== 1'b1 && n < 200);
    check(32'(o_addr3_mod), look ? 32'h5A : 32'h0);
    @(posedge i_core_clk);
    i_set_valid <= 1'b0;
    i_xbar_sel <= 36'h0;
    i_mul_ctrl <= 24'h0;
    i_alu_ctrl <= 80'h0;
    i_first_pair_imag <= 24'h0;
    steal_go <= steal;
    n = 1;
    do begin
      @(posedge i_core_clk);
      steal_go <= 1'b0;
      #1 n++;
    end while (o_res_valid !== 1'b1 && n < 400);
    check(n, 3 * `PA_STAGE_CYC + (steal ? STEAL_LEN : 0));
    check(32'(o_mult_out_one), 32'h1);
    check(32'(o_mult_out_two), 32'h0);
    check(32'(o_mult_out_three), look ? 32'hA05A : 32'h123456);
    check(32'(o_mult_out_four), 32'h7);
    check(32'(o_res_mask), 32'hF);
    check(32'(o_nsn_valid), 32'h1);
    check(32'(o_shifts_to_normalize), look ? 32'h7 : 32'h2);
    reg_rd(`PA_REG_ACC0 + 8'h04, 32'h1);
    $display("run_pass done look=%0b steal=%0b", look, steal);
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    {bad_count, checked, cyc} = '0;
    {i_core_clk, i_reg_wr, i_reg_rd, i_set_valid, steal_go} = '0;
    {i_char_lookup, i_dbl, i_reg_addr, i_reg_wdata, i_xbar_sel} = '0;
    {i_first_pair_real, i_first_pair_imag, i_second_pair_real} = '0;
    {i_second_pair_imag, i_third_source_operand_re} = '0;
    {i_third_source_operand_im, i_fourth_source_operand_re} = '0;
    {i_fourth_source_operand_im, i_mul_ctrl, i_alu_ctrl} = '0;
    {i_lzc_en, i_func_end, i_char_code} = 5'h1B;
    i_rst = 1'b1;
    repeat (16) @(posedge i_core_clk);
    i_rst <= 1'b0;
    test_regs();
    run_pass(1'b0, 1'b0);
    run_pass(1'b1, 1'b1);
    summarize();
  end
endmodule
